/* File: hdl/sar_adc_ctrl.sv */
// converter end: registers, sample/convert sequencer, result buffer, dma feed
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
module sar_adc_ctrl import adc_seq_pkg::*; #(
	parameter int BUF_DEPTH = BUF_WORDS
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic        trig_pin,
	input  wire logic        cmp_pin,
	output logic      [11:0] dac_code,
	output logic      [3:0]  in_sel,
	output logic      [1:0]  conv_sel,
	output logic      [3:0]  sh_hold,
	output logic      [2:0]  vref_sel,
	output logic      [15:0] pin_analog,
	output logic             irq,
	adc_dma_if.conv          link
);
	localparam int BI_W = $clog2(BUF_DEPTH);

	logic [15:0] c1_r, c1_nxt, c2_r, c2_nxt, c3_r, c3_nxt, pcfg_r, pcfg_nxt;
	logic [3:0]  chsel_r, chsel_nxt;
	logic [1:0]  mask_r, mask_nxt, st_clr;
	logic [2:0]  dcfg_r, dcfg_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic        irq_r, start_pulse;
	logic        trig_s1_r, trig_s2_r, trig_s3_r;
	logic [15:0] buf_mem [BUF_DEPTH];
	logic [15:0] addr_mem [BUF_DEPTH];

	seq_state_t  st_r, st_nxt;
	logic [4:0]  samp_r, samp_nxt;
	logic [9:0]  pace_r, pace_nxt;
	logic [1:0]  sh_r, sh_nxt;
	logic [3:0]  hold_r, hold_nxt, insel_r, insel_nxt, scan_r, scan_nxt;
	logic        eng_go_r, eng_go_nxt, done_r, done_nxt, ovf_r, ovf_nxt;
	logic [BI_W-1:0] wr_idx_r, wr_idx_nxt, rd_idx_r, rd_idx_nxt;
	logic [BI_W:0]   pend_r, pend_nxt;
	logic [3:0]  samples_per_pointer_increment_r, samples_per_pointer_increment_nxt;
	logic [15:0] ptr_r, ptr_nxt;
	logic        req_r, req_nxt;
	logic [15:0] daddr_r, daddr_nxt, ddata_r, ddata_nxt;
	logic        buf_we, pop, trig, eng_done;
	logic [15:0] buf_wdata, buf_waddr, blk_mask;
	logic [11:0] eng_res;
	logic [2:0]  nsh;
	logic [3:0]  conv_in;

	function automatic logic [3:0] next_scan(input logic [3:0] cur,
		input logic [15:0] en);
		logic [3:0] c;
		next_scan = cur;
		c = cur;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			c = (c == 4'(NUM_INPUTS - 1)) ? 4'h0 : c + 4'h1;
			if (en[c] && next_scan == cur)
				next_scan = c;
		end
	endfunction

	function automatic logic [15:0] fmt(input logic [11:0] raw,
		input logic [1:0] form, input logic res12);
		logic [15:0] half;
		half = res12 ? 16'h0800 : 16'h0200;
		if (form == FORM_SINT)
			fmt = {4'h0, raw} - half;
		else if (form == FORM_FRAC)
			fmt = res12 ? {raw, 4'h0} : {raw[9:0], 6'h00};
		else
			fmt = {4'h0, raw};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register file

	always_comb begin
		c1_nxt      = c1_r;
		c2_nxt      = c2_r;
		c3_nxt      = c3_r;
		pcfg_nxt    = pcfg_r;
		chsel_nxt   = chsel_r;
		mask_nxt    = mask_r;
		dcfg_nxt    = dcfg_r;
		rdata_nxt   = 16'h0000;
		st_clr      = 2'h0;
		start_pulse = 1'b0;
		if (wr) begin
			if (addr == OFS_CTRL1) begin
				c1_nxt = wdata & C1_WMASK;
				// a live module keeps its resolution
				if (c1_r[C1_ON])
					c1_nxt[C1_RES] = c1_r[C1_RES];
				start_pulse = wdata[C1_START];
			end else if (addr == OFS_CTRL2) begin
				c2_nxt = wdata;
			end else if (addr == OFS_CTRL3) begin
				c3_nxt = wdata;
			end else if (addr == OFS_PCFG) begin
				pcfg_nxt = {3'h0, wdata[NUM_INPUTS-1:0]};
			end else if (addr == OFS_CHSEL) begin
				chsel_nxt = (wdata[3:0] < 4'(NUM_INPUTS)) ? wdata[3:0]
					: chsel_r;
			end else if (addr == OFS_STATUS) begin
				st_clr = wdata[1:0];
			end else if (addr == OFS_MASK) begin
				mask_nxt = wdata[1:0];
			end else if (addr == OFS_DMACFG) begin
				dcfg_nxt = wdata[2:0];
			end
		end
		if (rd) begin
			if (addr == OFS_CTRL1)
				rdata_nxt = c1_r;
			else if (addr == OFS_CTRL2)
				rdata_nxt = c2_r;
			else if (addr == OFS_CTRL3)
				rdata_nxt = c3_r;
			else if (addr == OFS_PCFG)
				rdata_nxt = pcfg_r;
			else if (addr == OFS_CHSEL)
				rdata_nxt = {12'h000, chsel_r};
			else if (addr == OFS_STATUS)
				rdata_nxt = {7'h00, st_r != SEQ_IDLE, 6'h00, ovf_r, done_r};
			else if (addr == OFS_MASK)
				rdata_nxt = {14'h0000, mask_r};
			else if (addr == OFS_DMACFG)
				rdata_nxt = {13'h0000, dcfg_r};
			else if (addr >= OFS_BUF && addr < OFS_BUF + 8'(4 * BUF_DEPTH))
				rdata_nxt = buf_mem[addr[BI_W+1:2]];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			c1_r    <= CTRL_RESET;
			c2_r    <= CTRL_RESET;
			c3_r    <= CTRL_RESET;
			pcfg_r  <= CTRL_RESET;
			chsel_r <= 4'h0;
			mask_r  <= 2'h0;
			dcfg_r  <= 3'h0;
			rdata_r <= 16'h0000;
			irq_r   <= 1'b0;
		end else begin
			c1_r    <= c1_nxt;
			c2_r    <= c2_nxt;
			c3_r    <= c3_nxt;
			pcfg_r  <= pcfg_nxt;
			chsel_r <= chsel_nxt;
			mask_r  <= mask_nxt;
			dcfg_r  <= dcfg_nxt;
			rdata_r <= rdata_nxt;
			irq_r   <= |({ovf_nxt, done_nxt} & mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer and dma feed

	sar_step u_sar (
		.clk      (clk),
		.reset_n  (reset_n),
		.start    (eng_go_r),
		.res12    (c1_r[C1_RES]),
		.div      (c3_r[C3_DIV_LO +: 8]),
		.cmp_pin  (cmp_pin),
		.busy     (),
		.done     (eng_done),
		.result   (eng_res),
		.dac_code (dac_code)
	);

	always_comb begin
		st_nxt     = st_r;
		samp_nxt   = samp_r;
		pace_nxt   = (pace_r != 10'h000) ? pace_r - 10'h001 : pace_r;
		sh_nxt     = sh_r;
		hold_nxt   = hold_r;
		insel_nxt  = insel_r;
		scan_nxt   = scan_r;
		eng_go_nxt = 1'b0;
		samples_per_pointer_increment_nxt   = samples_per_pointer_increment_r;
		ptr_nxt    = ptr_r;
		buf_we     = 1'b0;
		// twelve-bit mode has one hold; otherwise one, two or four
		nsh = c1_r[C1_RES] ? 3'h1 : (c2_r[C2_CHPS_LO +: 2] == 2'h0) ? 3'h1
			: (c2_r[C2_CHPS_LO +: 2] == 2'h1) ? 3'h2 : 3'h4;
		conv_in   = (sh_r == 2'h0) ? insel_r : {2'h0, sh_r};
		blk_mask  = (16'h0001 << dcfg_r) - 16'h0001;
		buf_wdata = fmt(eng_res, c1_r[C1_FORM_LO +: 2], c1_r[C1_RES]);
		buf_waddr = c1_r[C1_BUILD] ? 16'(wr_idx_r)
			: (16'(conv_in) << dcfg_r) | (ptr_r & blk_mask);
		case (c1_r[C1_TRIG_LO +: 3])
			TRIG_MANUAL: trig = start_pulse;
			TRIG_EXT:    trig = trig_s2_r & ~trig_s3_r;
			TRIG_AUTO:   trig = 1'b1;
			default:     trig = 1'b0;
		endcase
		case (st_r)
			SEQ_IDLE: begin
				if (c1_r[C1_ON] && trig && pace_r == 10'h000) begin
					st_nxt    = SEQ_SAMPLE;
					samp_nxt  = (c3_r[C3_SAMC_LO +: 5] == 5'h00) ? 5'h01
						: c3_r[C3_SAMC_LO +: 5];
					insel_nxt = c2_r[C2_SCAN] ? scan_r : chsel_r;
					pace_nxt  = c1_r[C1_RES] ? 10'(PACE12_CYC)
						: 10'(PACE10_CYC * nsh);
				end
			end
			SEQ_SAMPLE: begin
				samp_nxt = samp_r - 5'h01;
				if (samp_r == 5'h01) begin
					// all active holds close on the same edge
					hold_nxt   = 4'((5'h01 << nsh) - 5'h01);
					sh_nxt     = 2'h0;
					eng_go_nxt = 1'b1;
					st_nxt     = SEQ_CONV;
				end
			end
			SEQ_CONV: begin
				if (eng_done) begin
					buf_we     = 1'b1;
					if (samples_per_pointer_increment_r == c2_r[C2_SAMPLES_PER_POINTER_INCREMENT_LO +: 4]) begin
						samples_per_pointer_increment_nxt = 4'h0;
						ptr_nxt  = ptr_r + 16'h0001;
					end else begin
						samples_per_pointer_increment_nxt = samples_per_pointer_increment_r + 4'h1;
					end
					if (3'(sh_r) + 3'h1 < nsh) begin
						sh_nxt     = sh_r + 2'h1;
						eng_go_nxt = 1'b1;
					end else begin
						hold_nxt = 4'h0;
						sh_nxt   = 2'h0;
						// the scan pointer moves only in scan mode
						if (c2_r[C2_SCAN])
							scan_nxt = next_scan(scan_r, pcfg_r);
						st_nxt   = SEQ_IDLE;
					end
				end
			end
			default: st_nxt = SEQ_IDLE;
		endcase
		if (!c1_r[C1_ON]) begin
			st_nxt   = SEQ_IDLE;
			hold_nxt = 4'h0;
			sh_nxt   = 2'h0;
		end
	end

	// pending queue of results awaiting the dma channel
	always_comb begin
		pop        = link.ack & req_r;
		rd_idx_nxt = rd_idx_r + BI_W'(pop);
		wr_idx_nxt = wr_idx_r;
		pend_nxt   = pend_r - (BI_W+1)'(pop);
		done_nxt   = done_r & ~st_clr[ST_DONE];
		ovf_nxt    = ovf_r & ~st_clr[ST_OVF];
		if (buf_we) begin
			done_nxt = 1'b1;
			if (pend_r == (BI_W+1)'(BUF_DEPTH) && !pop) begin
				ovf_nxt = 1'b1;
			end else begin
				// a dropped result must not move the write slot
				wr_idx_nxt = wr_idx_r + 1'b1;
				pend_nxt   = pend_nxt + 1'b1;
			end
		end
		req_nxt   = pend_nxt != '0;
		ddata_nxt = buf_mem[rd_idx_nxt];
		daddr_nxt = addr_mem[rd_idx_nxt];
		// bypass: the entry being handed over may be written this cycle
		if (wr_idx_nxt != wr_idx_r && wr_idx_r == rd_idx_nxt) begin
			ddata_nxt = buf_wdata;
			daddr_nxt = buf_waddr;
		end
	end

	always_ff @(posedge clk) begin
		// a full queue with no pop this cycle drops the newest result and flags overflow
		if (buf_we && !(pend_r == (BI_W+1)'(BUF_DEPTH) && !pop)) begin
			buf_mem[wr_idx_r]  <= buf_wdata;
			addr_mem[wr_idx_r] <= buf_waddr;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trig_s1_r <= 1'b0;
			trig_s2_r <= 1'b0;
			trig_s3_r <= 1'b0;
			st_r      <= SEQ_IDLE;
			samp_r    <= 5'h00;
			pace_r    <= 10'h000;
			sh_r      <= 2'h0;
			hold_r    <= 4'h0;
			insel_r   <= 4'h0;
			scan_r    <= 4'h0;
			eng_go_r  <= 1'b0;
			wr_idx_r  <= '0;
			rd_idx_r  <= '0;
			pend_r    <= '0;
			samples_per_pointer_increment_r    <= 4'h0;
			ptr_r     <= 16'h0000;
			done_r    <= 1'b0;
			ovf_r     <= 1'b0;
			req_r     <= 1'b0;
			daddr_r   <= 16'h0000;
			ddata_r   <= 16'h0000;
		end else begin
			trig_s1_r <= trig_pin;
			trig_s2_r <= trig_s1_r;
			trig_s3_r <= trig_s2_r;
			st_r      <= st_nxt;
			samp_r    <= samp_nxt;
			pace_r    <= pace_nxt;
			sh_r      <= sh_nxt;
			hold_r    <= hold_nxt;
			insel_r   <= insel_nxt;
			scan_r    <= scan_nxt;
			eng_go_r  <= eng_go_nxt;
			wr_idx_r  <= wr_idx_nxt;
			rd_idx_r  <= rd_idx_nxt;
			pend_r    <= pend_nxt;
			samples_per_pointer_increment_r    <= samples_per_pointer_increment_nxt;
			ptr_r     <= ptr_nxt;
			done_r    <= done_nxt;
			ovf_r     <= ovf_nxt;
			req_r     <= req_nxt;
			daddr_r   <= daddr_nxt;
			ddata_r   <= ddata_nxt;
		end
	end

	assign rdata      = rdata_r;
	assign in_sel     = insel_r;
	assign conv_sel   = sh_r;
	assign sh_hold    = hold_r;
	assign vref_sel   = c2_r[C2_VREF_LO +: 3];
	assign pin_analog = pcfg_r;
	assign irq        = irq_r;
	assign link.req   = req_r;
	assign link.addr  = daddr_r;
	assign link.data  = ddata_r;
endmodule // sar_adc_ctrl

/* File: hdl/adc_seq_pkg.sv */
// shared constants and types for the converter sequencer and its dma feed
package adc_seq_pkg;
	localparam int CLK_HZ      = 100_000_000;
	localparam int RATE10_SPS  = 1_100_000;
	localparam int RATE12_SPS  = 500_000;
	// least spacing between sample starts, rounded up to whole cycles
	localparam int PACE10_CYC  = (CLK_HZ + RATE10_SPS - 1) / RATE10_SPS;
	localparam int PACE12_CYC  = (CLK_HZ + RATE12_SPS - 1) / RATE12_SPS;

	localparam int NUM_INPUTS  = 13;
	localparam int NUM_SH      = 4;
	localparam int BUF_WORDS   = 16;

	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL1  = 8'h00;
	localparam logic [7:0] OFS_CTRL2  = 8'h04;
	localparam logic [7:0] OFS_CTRL3  = 8'h08;
	localparam logic [7:0] OFS_PCFG   = 8'h0c;
	localparam logic [7:0] OFS_CHSEL  = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_MASK   = 8'h18;
	localparam logic [7:0] OFS_DMACFG = 8'h1c;
	localparam logic [7:0] OFS_BUF    = 8'h40;

	// converter_control_one fields
	localparam int C1_ON       = 15;
	localparam int C1_BUILD    = 12;
	localparam int C1_RES      = 10;
	localparam int C1_FORM_LO  = 8;
	localparam int C1_TRIG_LO  = 5;
	localparam int C1_START    = 1;
	localparam logic [15:0] C1_WMASK = 16'h97e0;
	// converter_control_two fields
	localparam int C2_VREF_LO  = 13;
	localparam int C2_SCAN     = 10;
	localparam int C2_CHPS_LO  = 8;
	localparam int C2_SAMPLES_PER_POINTER_INCREMENT_LO  = 2;
	// converter_control_three fields
	localparam int C3_SAMC_LO  = 8;
	localparam int C3_DIV_LO   = 0;
	// status and mask fields
	localparam int ST_DONE     = 0;
	localparam int ST_OVF      = 1;
	localparam int ST_BUSY     = 8;

	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// trigger sources
	localparam logic [2:0] TRIG_MANUAL = 3'h0;
	localparam logic [2:0] TRIG_EXT    = 3'h1;
	localparam logic [2:0] TRIG_AUTO   = 3'h7;

	// result formats
	localparam logic [1:0] FORM_UINT   = 2'h0;
	localparam logic [1:0] FORM_SINT   = 2'h1;
	localparam logic [1:0] FORM_FRAC   = 2'h2;

	// comparator sync latency plus one settle cycle per bit decision
	localparam logic [8:0] SAR_SETTLE  = 9'h003;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONV} seq_state_t;
	typedef enum logic [1:0] {D_IDLE, D_GAP} dma_state_t;
endpackage

/* File: hdl/adc_dma_if.sv */
// link between the converter and the dma channel that drains its results
`timescale 1ns/1ps
interface adc_dma_if;
	logic        req;
	logic [15:0] addr;
	logic [15:0] data;
	logic        ack;

	modport conv (output req, output addr, output data, input ack);
	modport dma  (input req, input addr, input data, output ack);
endinterface // adc_dma_if

/* File: hdl/sar_step.sv */
// successive approximation bit walker driving the dac code
`timescale 1ns/1ps
module sar_step import adc_seq_pkg::*; (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic        res12,
	input  wire logic [7:0]  div,
	input  wire logic        cmp_pin,
	output logic             busy,
	output logic             done,
	output logic [11:0]      result,
	output logic [11:0]      dac_code
);
	logic        cmp_s1_r, cmp_s2_r;
	logic        run_r, run_nxt;
	logic [3:0]  bit_r, bit_nxt;
	logic [8:0]  wait_r, wait_nxt;
	logic [11:0] dac_r, dac_nxt;
	logic [11:0] res_r, res_nxt;
	logic        done_r, done_nxt;
	logic [11:0] trial;
	logic [3:0]  top;

	always_comb begin
		run_nxt  = run_r;
		bit_nxt  = bit_r;
		wait_nxt = wait_r;
		dac_nxt  = dac_r;
		res_nxt  = res_r;
		done_nxt = 1'b0;
		trial    = dac_r;
		top      = res12 ? 4'hb : 4'h9;
		if (!run_r) begin
			if (start) begin
				run_nxt  = 1'b1;
				bit_nxt  = top;
				dac_nxt  = 12'h001 << top;
				wait_nxt = {1'b0, div} + SAR_SETTLE;
			end
		end else if (wait_r != 9'h000) begin
			wait_nxt = wait_r - 9'h001;
		end else begin
			// comparator low means the input sits below the trial code
			if (!cmp_s2_r)
				trial[bit_r] = 1'b0;
			if (bit_r == 4'h0) begin
				run_nxt  = 1'b0;
				done_nxt = 1'b1;
				res_nxt  = trial;
				dac_nxt  = trial;
			end else begin
				bit_nxt  = bit_r - 4'h1;
				dac_nxt  = trial | (12'h001 << (bit_r - 4'h1));
				wait_nxt = {1'b0, div} + SAR_SETTLE;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
			run_r    <= 1'b0;
			bit_r    <= 4'h0;
			wait_r   <= 9'h000;
			dac_r    <= 12'h000;
			res_r    <= 12'h000;
			done_r   <= 1'b0;
		end else begin
			cmp_s1_r <= cmp_pin;
			cmp_s2_r <= cmp_s1_r;
			run_r    <= run_nxt;
			bit_r    <= bit_nxt;
			wait_r   <= wait_nxt;
			dac_r    <= dac_nxt;
			res_r    <= res_nxt;
			done_r   <= done_nxt;
		end
	end

	assign busy     = run_r;
	assign done     = done_r;
	assign result   = res_r;
	assign dac_code = dac_r;
endmodule // sar_step

/* File: hdl/dma_feed_end.sv */
// dma channel end: takes each converter request and writes it to memory
`timescale 1ns/1ps
module dma_feed_end import adc_seq_pkg::*; (
	input  wire logic        clk,
	input  wire logic        reset_n,
	adc_dma_if.dma           link,
	input  wire logic        enable,
	input  wire logic [15:0] mem_base,
	output logic             mem_wr,
	output logic      [15:0] mem_addr,
	output logic      [15:0] mem_wdata,
	output logic      [15:0] xfer_count
);
	dma_state_t  st_r, st_nxt;
	logic        ack_r, ack_nxt, wr_r, wr_nxt;
	logic [15:0] addr_r, addr_nxt, data_r, data_nxt, cnt_r, cnt_nxt;

	always_comb begin
		st_nxt   = st_r;
		ack_nxt  = 1'b0;
		wr_nxt   = 1'b0;
		addr_nxt = addr_r;
		data_nxt = data_r;
		cnt_nxt  = cnt_r;
		case (st_r)
			D_IDLE: begin
				// one transfer per request; the gap lets req update
				if (enable && link.req) begin
					ack_nxt  = 1'b1;
					wr_nxt   = 1'b1;
					addr_nxt = mem_base + link.addr;
					data_nxt = link.data;
					cnt_nxt  = cnt_r + 16'h0001;
					st_nxt   = D_GAP;
				end
			end
			default: st_nxt = D_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r   <= D_IDLE;
			ack_r  <= 1'b0;
			wr_r   <= 1'b0;
			addr_r <= 16'h0000;
			data_r <= 16'h0000;
			cnt_r  <= 16'h0000;
		end else begin
			st_r   <= st_nxt;
			ack_r  <= ack_nxt;
			wr_r   <= wr_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			cnt_r  <= cnt_nxt;
		end
	end

	assign link.ack   = ack_r;
	assign mem_wr     = wr_r;
	assign mem_addr   = addr_r;
	assign mem_wdata  = data_r;
	assign xfer_count = cnt_r;
endmodule // dma_feed_end

/* File: tb/adc_link_checker.sv */
// concurrent checks on the converter to dma channel link
`timescale 1ns/1ps
module adc_link_checker (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        req,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] data,
	input  wire logic        ack
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////
	a_ack_pulse: assert property (ack |=> !ack)
		else $error("ack stayed high for a second cycle");
	a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
		else $error("ack without a pending request");
	a_quiet_link: assert property (!req |=> !ack)
		else $error("ack followed an idle request line");
	a_req_stands: assert property (req && !ack |=> req)
		else $error("request withdrawn before it was taken");
	a_addr_stands: assert property (req && !ack |=> $stable(addr))
		else $error("address moved while request pending");
	a_data_stands: assert property (req && !ack |=> $stable(data))
		else $error("data moved while request pending");
	a_req_falls: assert property ($fell(req) |-> $past(ack))
		else $error("request dropped without a transfer");
	// widest scatter address: input 12 shifted by size 7, full pointer
	a_addr_span: assert property (req |-> addr <= 16'h067f)
		else $error("link address beyond scatter range");
endmodule // adc_link_checker

/* File: tb/sar_adc_sequencer_dma_feed_test.sv */
// self-checking bench for the converter end and its dma channel end
`timescale 1ns/1ps
module sar_adc_sequencer_dma_feed_test import adc_seq_pkg::*;;
	logic        clk, reset_n, wr, rd, trig_pin, cmp_pin, irq;
	logic        enable, mem_wr, saw4, wide, h0;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata, mem_base, mem_addr, mem_wdata, xfer_count;
	logic [15:0] pin_analog;
	logic [11:0] dac_code;
	logic [3:0]  in_sel, sh_hold;
	logic [2:0]  vref_sel;
	logic [1:0]  conv_sel;
	logic [15:0] ma[$];
	logic [15:0] md[$];
	int          errors, total_checks, cyc, rise, gap;

	adc_dma_if adc_dma_if_inst ();
	sar_adc_ctrl sar_adc_ctrl_inst (
		.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .trig_pin(trig_pin),
		.cmp_pin(cmp_pin), .dac_code(dac_code), .in_sel(in_sel),
		.conv_sel(conv_sel), .sh_hold(sh_hold), .vref_sel(vref_sel),
		.pin_analog(pin_analog), .irq(irq), .link(adc_dma_if_inst));
	dma_feed_end dma_feed_end_inst (
		.clk(clk), .reset_n(reset_n), .link(adc_dma_if_inst),
		.enable(enable), .mem_base(mem_base), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.xfer_count(xfer_count));
	adc_link_checker adc_link_checker_inst (
		.clk(clk), .reset_n(reset_n), .req(adc_dma_if_inst.req),
		.addr(adc_dma_if_inst.addr), .data(adc_dma_if_inst.data),
		.ack(adc_dma_if_inst.ack));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	// memory writes, hold activity and spacing of sample starts
	always @(posedge clk) begin
		cyc++;
		if (sh_hold === 4'hf) saw4 = 1'b1;
		if (sh_hold[3:1] !== 3'h0) wide = 1'b1;
		if (sh_hold[0] === 1'b1 && h0 !== 1'b1) begin
			gap = cyc - rise;
			rise = cyc;
		end
		h0 = sh_hold[0];
		if (mem_wr === 1'b1) begin
			ma.push_back(mem_addr);
			md.push_back(mem_wdata);
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		if (errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic put_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	// fixed wait covers the longest pace reload of four holds
	task automatic go(input logic [15:0] c);
		// start is only seen once the module is already on
		put_reg(OFS_CTRL1, c);
		put_reg(OFS_CTRL1, c | 16'h0002);
		repeat (400) @(posedge clk);
	endtask

	task automatic pulse;
		@(posedge clk);
		trig_pin <= 1'b1;
		repeat (4) @(posedge clk);
		trig_pin <= 1'b0;
		repeat (400) @(posedge clk);
	endtask

	task automatic wait_xfer(input logic [15:0] n);
		for (int i = 0; i < 3000 && xfer_count !== n; i++) @(posedge clk);
		// let the capture process log the last write first
		#1;
		if (xfer_count !== n) begin
			chk(xfer_count, n);
			report_and_stop();
		end
	endtask

	// allows two cycles of slack; the next auto start comes the cycle after the pace count reaches zero
	task automatic pace(input logic [15:0] c, input int p);
		put_reg(OFS_CTRL1, c);
		repeat (900) @(posedge clk);
		put_reg(OFS_CTRL1, c & 16'h7fff);
		chk(16'(gap >= p && gap <= p + 2), 16'h0001);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		{reset_n, wr, rd, trig_pin, enable} = '0;
		{saw4, wide, h0} = '0;
		cmp_pin = 1'b1;
		mem_base = 16'h1000;
		addr = 8'h00;
		wdata = 16'h0000;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		enable <= 1'b1;
		rd_chk(OFS_CTRL1, CTRL_RESET);
		rd_chk(OFS_STATUS, 16'h0000);
		put_reg(8'h20, 16'hffff);
		rd_chk(8'h20, 16'h0000);
		put_reg(OFS_PCFG, 16'h1fff);
		put_reg(OFS_CTRL2, 16'h0000);
		put_reg(OFS_CTRL3, 16'h0100);
		put_reg(OFS_CHSEL, 16'h0005);
		put_reg(OFS_CTRL1, 16'h1000);
		put_reg(OFS_STATUS, 16'h0003);
		put_reg(OFS_MASK, 16'h0001);
		go(16'h9000);
		wait_xfer(16'd1);
		chk(ma[0], 16'h1000);
		chk(md[0], 16'h03ff);
		chk({12'h000, in_sel}, 16'h0005);
		rd_chk(OFS_BUF, 16'h03ff);
		rd_chk(OFS_STATUS, 16'h0001);
		chk({15'h0000, irq}, 16'h0001);
		// channel held off: both results must wait, none lost
		enable <= 1'b0;
		go(16'h9000);
		go(16'h9000);
		chk(xfer_count, 16'd1);
		enable <= 1'b1;
		wait_xfer(16'd3);
		chk(ma[2], 16'h1002);
		put_reg(OFS_MASK, 16'h0000);
		rd_chk(OFS_STATUS, 16'h0001);
		chk({15'h0000, irq}, 16'h0000);
		put_reg(OFS_MASK, 16'h0001);
		put_reg(OFS_STATUS, 16'h0001);
		rd_chk(OFS_STATUS, 16'h0000);
		chk({15'h0000, irq}, 16'h0000);
		put_reg(OFS_CTRL1, 16'h9400);
		rd_chk(OFS_CTRL1, 16'h9000);
		put_reg(OFS_CTRL1, 16'h1000);
		put_reg(OFS_CTRL1, 16'h1400);
		put_reg(OFS_CTRL2, 16'h0200);
		put_reg(OFS_CTRL1, 16'h9400);
		rd_chk(OFS_CTRL1, 16'h9400);
		wide = 1'b0;
		go(16'h9400);
		wait_xfer(16'd4);
		chk(md[3], 16'h0fff);
		chk({15'h0000, wide}, 16'h0000);
		put_reg(OFS_CTRL1, 16'h1000);
		saw4 = 1'b0;
		go(16'h9000);
		wait_xfer(16'd8);
		chk({15'h0000, saw4}, 16'h0001);
		chk(md[7], 16'h03ff);
		put_reg(OFS_CTRL2, 16'h0000);
		// low comparator gives code zero; signed and left-justified forms
		cmp_pin <= 1'b0;
		go(16'h9100);
		wait_xfer(16'h0009);
		chk(md[8], 16'hfe00);
		chk({4'h0, dac_code}, 16'h0000);
		cmp_pin <= 1'b1;
		go(16'h9200);
		wait_xfer(16'h000a);
		chk(md[9], 16'hffc0);
		chk({4'h0, dac_code}, 16'h03ff);
		pace(16'h90e0, PACE10_CYC);
		put_reg(OFS_CTRL1, 16'h1400);
		pace(16'h94e0, PACE12_CYC);
		// second reset in mid-run, then scatter addressing by input
		reset_n <= 1'b0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		ma.delete();
		put_reg(OFS_CTRL3, 16'h0100);
		put_reg(OFS_PCFG, 16'h1001);
		put_reg(OFS_DMACFG, 16'h0002);
		put_reg(OFS_CTRL2, 16'he004);
		put_reg(OFS_CHSEL, 16'h000c);
		put_reg(OFS_CHSEL, 16'h000d);
		rd_chk(OFS_CHSEL, 16'h000c);
		chk(pin_analog, 16'h1001);
		chk({13'h0000, vref_sel}, 16'h0007);
		put_reg(OFS_CTRL1, 16'h8020);
		repeat (3) pulse();
		wait_xfer(16'd3);
		chk(ma[0], 16'h1030);
		chk(ma[1], 16'h1030);
		chk(ma[2], 16'h1031);
		put_reg(OFS_CTRL1, 16'h0020);
		put_reg(OFS_CTRL2, 16'h0400);
		put_reg(OFS_CTRL1, 16'h8020);
		pulse();
		chk({12'h000, in_sel}, 16'h0000);
		pulse();
		chk({12'h000, in_sel}, 16'h000c);
		enable <= 1'b0;
		repeat (17) pulse();
		rd_chk(OFS_STATUS, 16'h0003);
		enable <= 1'b1;
		wait_xfer(16'd21);
		report_and_stop();
	end
endmodule // sar_adc_sequencer_dma_feed_test
